// [pmon_readout.sv]
/*
 * Serial slave command layer of a rail power monitor: holds the
 * configuration word and the single measurement result and serves them
 * over a two-wire management bus.
 * Assumes scl_i and sda_i are synchronous to sys_clk_i and that the
 * measurement core presents a raw signed count with a load strobe.
 */
`timescale 1ns/1ps

module pmon_readout
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h40 // Arbitrary default address.
)
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Two-wire bus, data pin split into level and open-drain drive.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Measurement core side.
    input wire logic signed [10:0] raw_count_i,
    input wire logic raw_valid_i,
    output logic [15:0] cfg_o,
    output logic [1:0] meas_sel_o,
    output logic [15:0] result_o
);

    // =====================================================================
    // Types and helpers
    // =====================================================================
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK_SET, ST_ACK_HOLD,
        ST_TX, ST_TX_END, ST_MACK, ST_TX_LOAD
    } state_t;

    // Which byte the receiver is collecting.
    typedef enum logic [1:0] {K_ADDR, K_CMD, K_WLO, K_WHI} kind_t;

    // Word that a read answers with, by command.
    function automatic logic [15:0] read_word(input logic [7:0] cmd,
                                              input logic [15:0] cfg,
                                              input logic [15:0] res);
        case (cmd)
            pmon_pkg::CMD_CONFIG: read_word = cfg;
            pmon_pkg::CMD_RD_VOLT,
            pmon_pkg::CMD_RD_CURR,
            pmon_pkg::CMD_RD_POWER: read_word = res;
            default: read_word = pmon_pkg::IDLE_WORD;
        endcase
    endfunction

    // =====================================================================
    // Bus events
    // =====================================================================
    logic scl_rise, scl_fall, bus_start, bus_stop, sda_in;

    pmon_bus_cond pmon_bus_cond_i (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_rise_o(scl_rise),
        .scl_fall_o(scl_fall),
        .start_o(bus_start),
        .stop_o(bus_stop),
        .sda_o(sda_in)
    );

    // =====================================================================
    // Protocol state
    // =====================================================================
    state_t state_q, state_d;
    kind_t kind_q, kind_d;
    logic [2:0] cnt_q, cnt_d;       // Bit counter within a byte.
    logic [7:0] shift_q, shift_d;   // Receive shifter.
    logic [7:0] tx_q, tx_d;         // Transmit shifter.
    logic rd_q, rd_d;               // Direction of the current transfer.
    logic hi_q, hi_d;               // Second byte of a two-byte read.
    logic [7:0] cmd_q, cmd_d;       // Last command code.
    logic [7:0] wlo_q, wlo_d;       // Held low byte of a write.
    logic [15:0] cfg_q, cfg_d;      // Configuration word.
    logic [15:0] res_q, res_d;      // Result register.
    logic sda_oe_q, sda_oe_d;       // Open-drain pull-down.
    logic commit;                   // Config write completes this cycle.
    logic signed [10:0] clamped;    // Core count after range limiting.
    logic [15:0] rword;             // Word the current read answers with.

    assign rword = read_word(cmd_q, cfg_q, res_q);

    // Byte level sequencing; the start condition always restarts address
    // reception, which covers both a fresh and a repeated start.
    always_comb
    begin
        state_d = state_q;
        kind_d = kind_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        rd_d = rd_q;
        hi_d = hi_q;
        cmd_d = cmd_q;
        wlo_d = wlo_q;
        sda_oe_d = sda_oe_q;
        commit = 1'b0;
        if (bus_start)
        begin
            state_d = ST_RX;
            kind_d = K_ADDR;
            cnt_d = 3'h0;
            sda_oe_d = 1'b0;
        end
        else if (bus_stop)
        begin
            state_d = ST_IDLE;
            sda_oe_d = 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    sda_oe_d = 1'b0;
                end
                ST_RX:
                begin
                    // Bits are taken while the clock is high.
                    if (scl_rise)
                    begin
                        shift_d = {shift_q[6:0], sda_in};
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7)
                        begin
                            state_d = ST_ACK_SET;
                        end
                    end
                end
                ST_ACK_SET:
                begin
                    if (scl_fall)
                    begin
                        // A foreign address is left unanswered.
                        if (kind_q == K_ADDR && shift_q[7:1] != SLAVE_ADDR)
                        begin
                            state_d = ST_IDLE;
                        end
                        else
                        begin
                            sda_oe_d = 1'b1;
                            state_d = ST_ACK_HOLD;
                            case (kind_q)
                                K_ADDR: rd_d = shift_q[0];
                                K_CMD: cmd_d = shift_q;
                                K_WLO: wlo_d = shift_q;
                                default: commit = (cmd_q ==
                                    pmon_pkg::CMD_CONFIG);
                            endcase
                        end
                    end
                end
                ST_ACK_HOLD:
                begin
                    if (scl_fall)
                    begin
                        cnt_d = 3'h0;
                        state_d = ST_RX;
                        if (kind_q == K_ADDR && rd_q)
                        begin
                            // Low byte goes first on every read.
                            tx_d = rword[7:0];
                            sda_oe_d = !rword[7];
                            hi_d = 1'b0;
                            state_d = ST_TX;
                        end
                        else
                        begin
                            sda_oe_d = 1'b0;
                            case (kind_q)
                                K_ADDR: kind_d = K_CMD;
                                K_CMD: kind_d = K_WLO;
                                default: kind_d = K_WHI;
                            endcase
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_rise)
                    begin
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7)
                        begin
                            state_d = ST_TX_END;
                        end
                    end
                    else if (scl_fall)
                    begin
                        tx_d = {tx_q[6:0], 1'b0};
                        sda_oe_d = !tx_q[6];
                    end
                end
                ST_TX_END:
                begin
                    // Free the line for the host's answer bit.
                    if (scl_fall)
                    begin
                        sda_oe_d = 1'b0;
                        state_d = ST_MACK;
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        // NACK or second byte done ends the read.
                        if (!sda_in && !hi_q)
                        begin
                            hi_d = 1'b1;
                            tx_d = rword[15:8];
                            state_d = ST_TX_LOAD;
                        end
                        else
                        begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                ST_TX_LOAD:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_d = !tx_q[7];
                        cnt_d = 3'h0;
                        state_d = ST_TX;
                    end
                end
                default:
                begin
                    state_d = ST_IDLE;
                    sda_oe_d = 1'b0;
                end
            endcase
        end
    end

    // =====================================================================
    // Result and configuration
    // =====================================================================
    // Limit the core count to full scale; voltage is floored at zero.
    // Clamping here keeps a misbehaving core from wrapping the sign bit.
    always_comb
    begin
        clamped = raw_count_i;
        if (raw_count_i > pmon_pkg::FS_POS)
        begin
            clamped = pmon_pkg::FS_POS;
        end
        else if (raw_count_i < pmon_pkg::FS_NEG)
        begin
            clamped = pmon_pkg::FS_NEG;
        end
        if (cfg_q[pmon_pkg::CFG_SEL_MSB:pmon_pkg::CFG_SEL_LSB] ==
            pmon_pkg::SEL_VOLT && raw_count_i[10])
        begin
            clamped = 11'sh000;
        end
        res_d = res_q;
        if (raw_valid_i)
        begin
            // Pad bits below the binary point are always zero.
            res_d = {clamped[9:0],
                {pmon_pkg::RES_PAD_BITS{1'b0}}};
        end
        cfg_d = commit ? {shift_q, wlo_q} : cfg_q;
    end

    // All control state returns to idle with the bus released.
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= ST_IDLE;
            kind_q <= K_ADDR;
            cnt_q <= 3'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            rd_q <= 1'b0;
            hi_q <= 1'b0;
            cmd_q <= 8'h00;
            wlo_q <= 8'h00;
            sda_oe_q <= 1'b0;
            cfg_q <= pmon_pkg::CFG_RESET;
            res_q <= pmon_pkg::RES_RESET;
        end
        else
        begin
            state_q <= state_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            rd_q <= rd_d;
            hi_q <= hi_d;
            cmd_q <= cmd_d;
            wlo_q <= wlo_d;
            sda_oe_q <= sda_oe_d;
            cfg_q <= cfg_d;
            res_q <= res_d;
        end
    end

    // Open drain: the data level driven is always low.
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_q;
    assign cfg_o = cfg_q;
    assign meas_sel_o =
        cfg_q[pmon_pkg::CFG_SEL_MSB:pmon_pkg::CFG_SEL_LSB];
    assign result_o = res_q;

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    pad_zero_a:
    assert property (res_q[5:0] == 6'h00)
    else $error("result pad bits not zero");

    full_scale_a:
    assert property (raw_valid_i && raw_count_i > pmon_pkg::FS_POS
        |=> res_q == 16'h4000)
    else $error("positive overrange not clamped");

    volt_floor_a:
    assert property (raw_valid_i && raw_count_i[10] &&
        meas_sel_o == pmon_pkg::SEL_VOLT |=> res_q == 16'h0000)
    else $error("negative voltage reported");

    same_word_a:
    assert property (state_q == ST_ACK_HOLD && scl_fall && rd_q &&
        kind_q == K_ADDR && (cmd_q == pmon_pkg::CMD_RD_VOLT ||
        cmd_q == pmon_pkg::CMD_RD_CURR || cmd_q == pmon_pkg::CMD_RD_POWER)
        |=> tx_q == $past(res_q[7:0]))
    else $error("read command did not return result");

    ack_drive_a:
    assert property (state_q == ST_ACK_HOLD |-> sda_oe_q)
    else $error("acknowledge not held low");

    release_a:
    assert property (state_q == ST_MACK |-> !sda_oe_q)
    else $error("line not released for host answer");

    cfg_write_a:
    assert property (commit |=> cfg_q == {$past(shift_q), $past(wlo_q)}
        ##1 $stable(cfg_q))
    else $error("config write not stored");

    sel_map_a:
    assert property (commit |=> meas_sel_o == wlo_q[7:6])
    else $error("select field mismatch");

    addr_ignore_a:
    assert property (state_q == ST_ACK_SET && scl_fall &&
        kind_q == K_ADDR && shift_q[7:1] != SLAVE_ADDR
        |=> !sda_oe_q && state_q == ST_IDLE)
    else $error("foreign address answered");

    cfg_write_c: cover property (commit);
    read_two_c: cover property (state_q == ST_MACK && hi_q && scl_rise);
    volt_clamp_c: cover property (raw_valid_i && raw_count_i[10] &&
        meas_sel_o == pmon_pkg::SEL_VOLT);

endmodule

// [pmon_pkg.sv]
/*
 * Shared constants for the rail power monitor serial readout: command
 * codes, configuration field positions, reset values and result scaling.
 * Assumes nothing of its surroundings; every design file that uses it
 * refers to it by its full scoped name.
 */
package pmon_pkg;

    // =====================================================================
    // Command codes
    // =====================================================================
    // Configuration word access.
    localparam logic [7:0] CMD_CONFIG = 8'hd0;
    // Result reads, all three return the same word.
    localparam logic [7:0] CMD_RD_VOLT = 8'h8b;
    localparam logic [7:0] CMD_RD_CURR = 8'h8c;
    localparam logic [7:0] CMD_RD_POWER = 8'h96;

    // =====================================================================
    // Configuration word layout
    // =====================================================================
    // Measurement select field occupies d7:d6.
    localparam int CFG_SEL_LSB = 6;
    localparam int CFG_SEL_MSB = 7;
    // Every field powers up at zero, so power is measured first.
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // Measurement select encodings.
    localparam logic [1:0] SEL_POWER = 2'h0;
    localparam logic [1:0] SEL_VOLT = 2'h1;
    localparam logic [1:0] SEL_CURR = 2'h2;

    // =====================================================================
    // Result word layout
    // =====================================================================
    // Six zero pad bits sit below the binary point.
    localparam int RES_PAD_BITS = 6;
    localparam logic [15:0] RES_RESET = 16'h0000;
    // Full scale counts, positive and negative.
    localparam logic signed [10:0] FS_POS = 11'sh100;
    localparam logic signed [10:0] FS_NEG = -11'sh100;
    // Answer for a read of a command that holds no data.
    localparam logic [15:0] IDLE_WORD = 16'hffff;

endpackage

// [pmon_bus_cond.sv]
/*
 * Bus condition detector for the serial management link: reports clock
 * edges and start and stop conditions as one-cycle pulses.
 * Assumes the clock and data lines are already synchronous to sys_clk_i.
 */
`timescale 1ns/1ps

module pmon_bus_cond
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Bus lines as seen on the wire.
    input wire logic scl_i,
    input wire logic sda_i,
    // Decoded events.
    output logic scl_rise_o,
    output logic scl_fall_o,
    output logic start_o,
    output logic stop_o,
    output logic sda_o
);

    // =====================================================================
    // Line history
    // =====================================================================
    // Previous line levels, released high like an idle bus.
    logic scl_q, scl_d;
    logic sda_q, sda_d;

    // Next values are simply the current lines.
    always_comb
    begin
        scl_d = scl_i;
        sda_d = sda_i;
    end

    // Idle bus is high on both lines, so reset to high avoids a false edge.
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // =====================================================================
    // Event decode
    // =====================================================================
    // A data change while the clock stays high marks start or stop.
    assign scl_rise_o = scl_i && !scl_q;
    assign scl_fall_o = !scl_i && scl_q;
    assign start_o = scl_i && scl_q && sda_q && !sda_i;
    assign stop_o = scl_i && scl_q && !sda_q && sda_i;
    assign sda_o = sda_i;

endmodule

// [pmon_host_model.sv]
/*
 * Behavioural two-wire bus host that frames packets for the power
 * monitor readout: start, stop, byte writes and byte reads.
 * Assumes the bench resolves the open-drain data line with a pull-up
 * and feeds the resolved level back on sda_i.
 */
`timescale 1ns/1ps

module pmon_host_model
(
    // Clock that paces the bus phases.
    input wire logic sys_clk_i,
    // Resolved data line level.
    input wire logic sda_i,
    // Bus clock and open-drain data pull.
    output logic scl_o,
    output logic sda_pull_o
);
    // =====================================================================
    // Bus phases
    // =====================================================================
    // Both lines idle high: the clock is driven high, the data is released to the pull-up.
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // Waits n falling edges; every line change of the host lands there.
    task automatic gap(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    // One bit slot. Data moves only while the clock is low, and the extra
    // cycle after the clock falls keeps a data change apart from the fall,
    // so the device never mistakes it for a start or stop.
    task automatic bit_io(input logic b, output logic r);
        sda_pull_o = ~b;
        gap(4);
        scl_o = 1'b1;
        gap(3);
        r = sda_i;
        scl_o = 1'b0;
        gap(1);
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic bus_start();
        sda_pull_o = 1'b0;
        gap(3);
        scl_o = 1'b1;
        gap(4);
        sda_pull_o = 1'b1;
        gap(4);
        scl_o = 1'b0;
        gap(1);
    endtask

    // Stop: data rises while the clock is high, leaving the bus idle.
    task automatic bus_stop();
        sda_pull_o = 1'b1;
        gap(3);
        scl_o = 1'b1;
        gap(4);
        sda_pull_o = 1'b0;
        gap(4);
    endtask

    // Byte to the device, MSB first; a low ninth bit is an ack.
    task automatic byte_wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Byte from the device; nack high ends the read.
    task automatic byte_rd(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule

// [power_monitor_smbus_readout_tb_top.sv]
/*
 * Self-checking bench for the power monitor readout: configuration
 * writes and reads, result loads and result reads over the bus.
 * Assumes the host model file is compiled first and the package before.
 */
`timescale 1ns/1ps

module power_monitor_smbus_readout_tb_top;
    // =====================================================================
    // Signals
    // =====================================================================
    // A non-default address checks that the parameter reaches the decoder.
    localparam logic [6:0] ADDR = 7'h2a;
    logic sys_clk;
    logic resetn;
    logic scl;
    logic host_pull;
    wire sda_w;
    logic sda_o;
    logic sda_oe;
    logic signed [10:0] raw_count;
    logic raw_valid;
    logic [15:0] cfg;
    logic [1:0] sel;
    logic [15:0] res;
    int fail_count = 0;
    int tests_run = 0;
    logic [7:0] cmds [3] = '{pmon_pkg::CMD_RD_VOLT, pmon_pkg::CMD_RD_CURR,
        pmon_pkg::CMD_RD_POWER};
    logic signed [10:0] counts [7] = '{11'sh100, -11'sh100, 11'sh12c,
        -11'sh12c, 11'sh003, -11'sh005, 11'sh000};

    // Open drain with pull-up: low if either party pulls.
    assign sda_w = ~(host_pull | (sda_oe & ~sda_o));

    // =====================================================================
    // Instances
    // =====================================================================
    pmon_readout #(.SLAVE_ADDR(ADDR)) pmon_readout_i (.sys_clk_i(sys_clk),
        .resetn_i(resetn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .raw_count_i(raw_count), .raw_valid_i(raw_valid),
        .cfg_o(cfg), .meas_sel_o(sel), .result_o(res));

    pmon_host_model pmon_host_model_i (.sys_clk_i(sys_clk), .sda_i(sda_w),
        .scl_o(scl), .sda_pull_o(host_pull));

    // =====================================================================
    // Compare and report
    // =====================================================================
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Expected result word: clamp to full scale, no negative voltage,
    // then six zero pad bits under the binary point.
    function automatic logic [15:0] scale(input logic signed [10:0] c,
                                          input logic [1:0] s);
        logic signed [10:0] v;
        v = c;
        if (v > 11'sh100)
            v = 11'sh100;
        if (v < -11'sh100)
            v = -11'sh100;
        if (s == pmon_pkg::SEL_VOLT && v < 11'sh000)
            v = 11'sh000;
        return {v[9:0], 6'h00};
    endfunction

    // =====================================================================
    // Bus transactions
    // =====================================================================
    // Write packet; n data bytes, fewer than two for a truncated write.
    task automatic wr(input logic [7:0] cmd, input logic [15:0] w,
                      input int n);
        logic a;
        logic ok;
        pmon_host_model_i.bus_start();
        pmon_host_model_i.byte_wr({ADDR, 1'b0}, ok);
        pmon_host_model_i.byte_wr(cmd, a);
        ok &= a;
        if (n > 0)
        begin
            pmon_host_model_i.byte_wr(w[7:0], a);
            ok &= a;
        end
        if (n > 1)
        begin
            pmon_host_model_i.byte_wr(w[15:8], a);
            ok &= a;
        end
        pmon_host_model_i.bus_stop();
        chk1(ok, 1'b1); // Every byte is acknowledged
    endtask

    // Combined read: command, repeated start, low byte, high byte, nack.
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        logic a;
        logic ok;
        logic [7:0] lo;
        logic [7:0] hi;
        pmon_host_model_i.bus_start();
        pmon_host_model_i.byte_wr({ADDR, 1'b0}, ok);
        pmon_host_model_i.byte_wr(cmd, a);
        ok &= a;
        pmon_host_model_i.bus_start();
        pmon_host_model_i.byte_wr({ADDR, 1'b1}, a);
        ok &= a;
        pmon_host_model_i.byte_rd(1'b0, lo);
        pmon_host_model_i.byte_rd(1'b1, hi);
        pmon_host_model_i.bus_stop();
        chk1(ok, 1'b1); // Address and command acked
        chk16({hi, lo}, exp); // Low byte first
    endtask

    // One load strobe from the measurement core.
    task automatic load(input logic signed [10:0] c);
        @(negedge sys_clk);
        raw_count = c;
        raw_valid = 1'b1;
        @(negedge sys_clk);
        raw_valid = 1'b0;
        @(negedge sys_clk);
        chk16(res, scale(c, sel)); // Clamped and padded
    endtask

    // =====================================================================
    // Clock, watchdog and main sequence
    // =====================================================================
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Every bus task is fixed length, so a hang means a lost clock.
    initial
    begin
        #400us;
        fail_count++;
        results();
    end

    initial
    begin
        logic a;
        logic [15:0] w;
        resetn = 1'b0;
        raw_count = 11'sh000;
        raw_valid = 1'b0;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk16(cfg, pmon_pkg::CFG_RESET); // Power selected
        chk16(res, pmon_pkg::RES_RESET); // Result register
        chk1(sda_oe, 1'b0); // Line released
        chk1(sda_o, 1'b0); // Open drain only pulls low
        // A foreign address is not acknowledged.
        pmon_host_model_i.bus_start();
        pmon_host_model_i.byte_wr({ADDR ^ 7'h01, 1'b0}, a);
        pmon_host_model_i.bus_stop();
        chk1(a, 1'b0); // Nack is high
        wr(pmon_pkg::CMD_CONFIG, 16'h5a47, 2); // Full write
        chk16(cfg, 16'h5a47); // Committed
        chk16({14'h0, sel}, {14'h0, pmon_pkg::SEL_VOLT});
        rd(pmon_pkg::CMD_CONFIG, 16'h5a47); // Read back
        // A write stopped after the low byte leaves the word alone.
        wr(pmon_pkg::CMD_CONFIG, 16'h0080, 1);
        chk16(cfg, 16'h5a47); // Truncated write dropped
        wr(pmon_pkg::CMD_RD_CURR, 16'h1234, 2); // Other command
        chk16(cfg, 16'h5a47); // Data to a read command dropped
        // Unknown codes stay clear of the reserved factory set.
        rd(8'h01, pmon_pkg::IDLE_WORD); // Idle word
        // Selection first, then loads, each read by a rotating command,
        // as the host must keep its selection current.
        for (int m = 0; m < 3; m++)
        begin
            w = {8'h00, 2'(m), 6'h00};
            wr(pmon_pkg::CMD_CONFIG, w, 2);
            chk16({14'h0, sel}, {14'h0, 2'(m)});
            for (int k = 0; k < 7; k++)
            begin
                load(counts[k]);
                rd(cmds[(k + m) % 3], scale(counts[k], 2'(m)));
            end
        end
        // Each command code at every mode is covered above.
        // Power mode loads ran through all codes as well.
        results();
    end
endmodule
